// *** src/irf_pkg.sv ***
// Package: register map, field positions and carrier types of the interrupt request flags
package irf_pkg;
  localparam int IRF_AW = 4;
  localparam int IRF_DW = 8;
  localparam int IRF_NPIN = 5;
  localparam int IRF_NWAKE = 8;

  localparam logic [IRF_AW-1:0] OFS_FLAGS_A = 4'h0;
  localparam logic [IRF_AW-1:0] OFS_FLAGS_B = 4'h1;
  localparam logic [IRF_AW-1:0] OFS_WAKE_FLAGS = 4'h2;
  localparam logic [IRF_AW-1:0] OFS_ENABLE_A = 4'h3;
  localparam logic [IRF_AW-1:0] OFS_ENABLE_B = 4'h4;
  localparam logic [IRF_AW-1:0] OFS_EDGE_SEL = 4'h5;
  localparam logic [IRF_AW-1:0] OFS_PIN_FUNC = 4'h6;
  localparam logic [IRF_AW-1:0] OFS_WAKE_FUNC = 4'h7;
  localparam logic [IRF_AW-1:0] OFS_TIMER_CTRL = 4'h8;

  // Group A fields
  localparam int BIT_TIMER_A = 7;
  localparam int BIT_SERIAL_ONE = 6;
  localparam int BIT_RESERVED = 5;
  localparam int BIT_WAKE_EN = 5;
  // Group B fields
  localparam int BIT_DIRECT = 7;
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_SERIAL_TWO = 5;
  localparam int BIT_TIMER_G = 4;
  localparam int BIT_TIMER_FH = 3;
  localparam int BIT_TIMER_FL = 2;
  localparam int BIT_TIMER_C = 1;
  localparam int BIT_TIMER_B = 0;
  // Timer control fields
  localparam int BIT_TG_FUNC = 0;
  localparam int BIT_TG_EDGE = 1;
  localparam int BIT_TF_WIDE = 2;

  localparam logic [IRF_DW-1:0] RST_FLAGS_A = 8'h20;
  localparam logic [IRF_DW-1:0] RST_ZERO = 8'h00;
  localparam logic [IRF_DW-1:0] CNT_ALL_ONES = 8'hff;
  localparam logic [IRF_DW-1:0] CNT_ZERO = 8'h00;

  typedef struct packed {
    logic [IRF_AW-1:0] addr;
    logic [IRF_DW-1:0] wdata;
    logic wr;
    logic rd;
  } irf_bus_t;

  typedef struct packed {
    logic [IRF_DW-1:0] timer_a_count;
    logic serial_one_done;
    logic direct_transfer_on;
    logic direct_transfer_after_sleep;
    logic converter_done;
    logic converter_start_busy;
    logic serial_two_done;
    logic serial_two_abort;
    logic [IRF_DW-1:0] timer_f_low_count;
    logic [IRF_DW-1:0] timer_f_high_count;
    logic [IRF_DW-1:0] timer_f_low_compare;
    logic [IRF_DW-1:0] timer_f_high_compare;
    logic [IRF_DW-1:0] timer_c_count;
    logic [IRF_DW-1:0] timer_b_count;
  } irf_periph_t;

  typedef enum logic [4:0] {
    SRC_NONE, SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_PIN3, SRC_PIN4, SRC_WAKE,
    SRC_TIMER_A, SRC_SERIAL_ONE, SRC_DIRECT, SRC_CONVERTER, SRC_SERIAL_TWO,
    SRC_TIMER_G, SRC_TIMER_FH, SRC_TIMER_FL, SRC_TIMER_C, SRC_TIMER_B
  } irf_source_t;
endpackage

// *** src/irf_flags.sv ***
// Interrupt request flag registers with pin edge detectors, enables and priority select
`timescale 1ns/1ps
module irf_flags
  import irf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire irf_bus_t bus,
  output logic [IRF_DW-1:0] rdata,
  input wire irf_periph_t periph,
  input wire logic [IRF_NPIN-1:0] request_pin,
  input wire logic [IRF_NWAKE-1:0] wake_pin,
  input wire logic timer_g_input_pin,
  output logic irq_pending,
  output irf_source_t irq_source
);

  logic [IRF_DW-1:0] interrupt_flags_group_a;
  logic [IRF_DW-1:0] interrupt_flags_group_b;
  logic [IRF_DW-1:0] wakeup_flags;
  logic [IRF_DW-1:0] enable_group_a;
  logic [IRF_DW-1:0] enable_group_b;
  logic [IRF_NPIN-1:0] edge_select;
  logic [IRF_NPIN-1:0] pin_function;
  logic [IRF_NWAKE-1:0] wake_function;
  logic [2:0] timer_ctrl;

  // Pin synchronisers: stage one feeds only stage two
  localparam int NSYNC = IRF_NPIN + IRF_NWAKE + 1;
  logic [NSYNC-1:0] sync_one;
  logic [NSYNC-1:0] sync_two;
  logic [NSYNC-1:0] sync_prev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_one <= '1;
      sync_two <= '1;
      sync_prev <= '1;
    end else begin
      sync_one <= {timer_g_input_pin, wake_pin, request_pin};
      sync_two <= sync_one;
      sync_prev <= sync_two;
    end
  end

  logic [IRF_NPIN-1:0] pin_now;
  logic [IRF_NPIN-1:0] pin_was;
  logic [IRF_NWAKE-1:0] wake_now;
  logic [IRF_NWAKE-1:0] wake_was;
  logic tg_now;
  logic tg_was;
  assign pin_now = sync_two[IRF_NPIN-1:0];
  assign pin_was = sync_prev[IRF_NPIN-1:0];
  assign wake_now = sync_two[IRF_NPIN+IRF_NWAKE-1:IRF_NPIN];
  assign wake_was = sync_prev[IRF_NPIN+IRF_NWAKE-1:IRF_NPIN];
  assign tg_now = sync_two[NSYNC-1];
  assign tg_was = sync_prev[NSYNC-1];

  // Previous samples of peripheral state for transition detection
  logic [IRF_DW-1:0] ta_prev;
  logic [IRF_DW-1:0] tb_prev;
  logic [IRF_DW-1:0] tc_prev;
  logic busy_prev;
  logic fh_match_prev;
  logic fl_match_prev;
  logic fw_match_prev;

  logic fh_match;
  logic fl_match;
  logic fw_match;
  assign fh_match = periph.timer_f_high_count == periph.timer_f_high_compare;
  assign fl_match = periph.timer_f_low_count == periph.timer_f_low_compare;
  assign fw_match = fh_match && fl_match;

  // Counters sampled every cycle so a wrap is seen once, on the step that makes it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ta_prev <= CNT_ZERO;
      tb_prev <= CNT_ZERO;
      tc_prev <= CNT_ZERO;
      busy_prev <= 1'b0;
      fh_match_prev <= 1'b1;
      fl_match_prev <= 1'b1;
      fw_match_prev <= 1'b1;
    end else begin
      ta_prev <= periph.timer_a_count;
      tb_prev <= periph.timer_b_count;
      tc_prev <= periph.timer_c_count;
      busy_prev <= periph.converter_start_busy;
      fh_match_prev <= fh_match;
      fl_match_prev <= fl_match;
      fw_match_prev <= fw_match;
    end
  end

  // Raw set conditions
  logic [IRF_DW-1:0] cond_a;
  logic [IRF_DW-1:0] cond_b;
  logic [IRF_NWAKE-1:0] cond_w;
  logic [IRF_DW-1:0] set_a;
  logic [IRF_DW-1:0] set_b;
  logic [IRF_NWAKE-1:0] set_w;
  logic tf_wide;
  assign tf_wide = timer_ctrl[BIT_TF_WIDE];

  always_comb begin
    cond_a = RST_ZERO;
    cond_b = RST_ZERO;
    cond_a[BIT_TIMER_A] = ta_prev == CNT_ALL_ONES && periph.timer_a_count == CNT_ZERO;
    cond_a[BIT_SERIAL_ONE] = periph.serial_one_done;
    for (int n = 0; n < IRF_NPIN; n++) begin
      // Rising when edge select is 1, falling otherwise
      cond_a[n] = pin_function[n] && (edge_select[n] ? (pin_now[n] && !pin_was[n])
                                                     : (!pin_now[n] && pin_was[n]));
    end
    cond_b[BIT_DIRECT] = periph.direct_transfer_on && periph.direct_transfer_after_sleep;
    cond_b[BIT_CONVERTER] = periph.converter_done && busy_prev
                            && !periph.converter_start_busy;
    cond_b[BIT_SERIAL_TWO] = periph.serial_two_done || periph.serial_two_abort;
    cond_b[BIT_TIMER_G] = timer_ctrl[BIT_TG_FUNC] && (timer_ctrl[BIT_TG_EDGE]
                          ? (tg_now && !tg_was) : (!tg_now && tg_was));
    cond_b[BIT_TIMER_FH] = tf_wide ? (fw_match && !fw_match_prev)
                                   : (fh_match && !fh_match_prev);
    cond_b[BIT_TIMER_FL] = !tf_wide && fl_match && !fl_match_prev;
    cond_b[BIT_TIMER_C] = (tc_prev == CNT_ALL_ONES && periph.timer_c_count == CNT_ZERO)
                       || (tc_prev == CNT_ZERO && periph.timer_c_count == CNT_ALL_ONES);
    cond_b[BIT_TIMER_B] = tb_prev == CNT_ALL_ONES && periph.timer_b_count == CNT_ZERO;
  end

  assign cond_w = wake_function & ~wake_now & wake_was;
  assign set_a = cond_a & enable_group_a & ~RST_FLAGS_A;
  assign set_b = cond_b & enable_group_b;
  assign set_w = cond_w & {IRF_NWAKE{enable_group_a[BIT_WAKE_EN]}};

  logic wr_a;
  logic wr_b;
  logic wr_w;
  assign wr_a = bus.wr && bus.addr == OFS_FLAGS_A;
  assign wr_b = bus.wr && bus.addr == OFS_FLAGS_B;
  assign wr_w = bus.wr && bus.addr == OFS_WAKE_FLAGS;

  logic [IRF_DW-1:0] next_flags_a;
  logic [IRF_DW-1:0] next_flags_b;
  logic [IRF_DW-1:0] next_wake;
  logic [IRF_DW-1:0] clr_a;
  logic [IRF_DW-1:0] clr_b;
  logic [IRF_DW-1:0] clr_w;
  assign clr_a = wr_a ? ~bus.wdata : RST_ZERO;
  assign clr_b = wr_b ? ~bus.wdata : RST_ZERO;
  assign clr_w = wr_w ? ~bus.wdata : RST_ZERO;
  // Set is ORed after the clear so a coincident event survives
  assign next_flags_a = (interrupt_flags_group_a & ~clr_a) | set_a | RST_FLAGS_A;
  assign next_flags_b = (interrupt_flags_group_b & ~clr_b) | set_b;
  assign next_wake = (wakeup_flags & ~clr_w) | set_w;

  // Flags only change by event or clearing write; acceptance has no path here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interrupt_flags_group_a <= RST_FLAGS_A;
      interrupt_flags_group_b <= RST_ZERO;
      wakeup_flags <= RST_ZERO;
    end else begin
      interrupt_flags_group_a <= next_flags_a;
      interrupt_flags_group_b <= next_flags_b;
      wakeup_flags <= next_wake;
    end
  end

  // Control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_group_a <= RST_ZERO;
      enable_group_b <= RST_ZERO;
      edge_select <= RST_ZERO[IRF_NPIN-1:0];
      pin_function <= RST_ZERO[IRF_NPIN-1:0];
      wake_function <= RST_ZERO;
      timer_ctrl <= RST_ZERO[2:0];
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_ENABLE_A: enable_group_a <= bus.wdata;
        OFS_ENABLE_B: enable_group_b <= bus.wdata;
        OFS_EDGE_SEL: edge_select <= bus.wdata[IRF_NPIN-1:0];
        OFS_PIN_FUNC: pin_function <= bus.wdata[IRF_NPIN-1:0];
        OFS_WAKE_FUNC: wake_function <= bus.wdata;
        OFS_TIMER_CTRL: timer_ctrl <= bus.wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= RST_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_FLAGS_A: rdata <= interrupt_flags_group_a | RST_FLAGS_A;
        OFS_FLAGS_B: rdata <= interrupt_flags_group_b;
        OFS_WAKE_FLAGS: rdata <= wakeup_flags;
        OFS_ENABLE_A: rdata <= enable_group_a;
        OFS_ENABLE_B: rdata <= enable_group_b;
        OFS_EDGE_SEL: rdata <= {3'h0, edge_select};
        OFS_PIN_FUNC: rdata <= {3'h0, pin_function};
        OFS_WAKE_FUNC: rdata <= wake_function;
        OFS_TIMER_CTRL: rdata <= {5'h00, timer_ctrl};
        default: rdata <= RST_ZERO;
      endcase
    end else begin
      rdata <= RST_ZERO;
    end
  end

  // Priority select over pending enabled flags, registered
  irf_source_t next_source;
  logic [IRF_DW-1:0] pend_a;
  logic [IRF_DW-1:0] pend_b;
  logic pend_w;
  assign pend_a = interrupt_flags_group_a & enable_group_a & ~RST_FLAGS_A;
  assign pend_b = interrupt_flags_group_b & enable_group_b;
  assign pend_w = |wakeup_flags && enable_group_a[BIT_WAKE_EN];

  always_comb begin
    next_source = SRC_NONE;
    if (pend_a[0]) next_source = SRC_PIN0;
    else if (pend_a[1]) next_source = SRC_PIN1;
    else if (pend_a[2]) next_source = SRC_PIN2;
    else if (pend_a[3]) next_source = SRC_PIN3;
    else if (pend_a[4]) next_source = SRC_PIN4;
    else if (pend_w) next_source = SRC_WAKE;
    else if (pend_a[BIT_TIMER_A]) next_source = SRC_TIMER_A;
    else if (pend_a[BIT_SERIAL_ONE]) next_source = SRC_SERIAL_ONE;
    else if (pend_b[BIT_DIRECT]) next_source = SRC_DIRECT;
    else if (pend_b[BIT_CONVERTER]) next_source = SRC_CONVERTER;
    else if (pend_b[BIT_SERIAL_TWO]) next_source = SRC_SERIAL_TWO;
    else if (pend_b[BIT_TIMER_G]) next_source = SRC_TIMER_G;
    else if (pend_b[BIT_TIMER_FH]) next_source = SRC_TIMER_FH;
    else if (pend_b[BIT_TIMER_FL]) next_source = SRC_TIMER_FL;
    else if (pend_b[BIT_TIMER_C]) next_source = SRC_TIMER_C;
    else if (pend_b[BIT_TIMER_B]) next_source = SRC_TIMER_B;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_source <= SRC_NONE;
      irq_pending <= 1'b0;
    end else begin
      irq_source <= next_source;
      irq_pending <= next_source != SRC_NONE;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ta_wrap;
    periph.timer_a_count == CNT_ALL_ONES
    ##1 periph.timer_a_count == CNT_ZERO && enable_group_a[BIT_TIMER_A];
  endsequence

  sequence s_pin0_fall;
    pin_function[0] && !edge_select[0] && enable_group_a[0] ##1 !sync_two[0] && sync_prev[0];
  endsequence

  chk_flag_sticky_a: assert property (
    interrupt_flags_group_a[BIT_TIMER_A] && !wr_a |=> interrupt_flags_group_a[BIT_TIMER_A])
    else $error("Timer A flag dropped without a clearing write");
  chk_write_one_noset: assert property (
    wr_b && bus.wdata[BIT_TIMER_B] && !interrupt_flags_group_b[BIT_TIMER_B] && !set_b[BIT_TIMER_B]
    |=> !interrupt_flags_group_b[BIT_TIMER_B])
    else $error("Writing 1 set a flag");
  chk_reserved_one: assert property (
    bus.rd && bus.addr == OFS_FLAGS_A |=> rdata[BIT_RESERVED])
    else $error("Reserved bit did not read as 1");
  chk_timer_a_wrap: assert property (
    s_ta_wrap |=> interrupt_flags_group_a[BIT_TIMER_A])
    else $error("Timer A overflow did not set its flag");
  chk_pin_fall: assert property (
    s_pin0_fall |=> interrupt_flags_group_a[0])
    else $error("Falling edge on request pin 0 did not set its flag");
  chk_wake_fall: assert property (
    set_w[3] |=> wakeup_flags[3] [*2] or (wakeup_flags[3] ##1 $past(wr_w)))
    else $error("Wake flag 3 did not set on its edge");
  chk_set_wins: assert property (
    set_a[BIT_SERIAL_ONE] && wr_a && !bus.wdata[BIT_SERIAL_ONE]
    |=> interrupt_flags_group_a[BIT_SERIAL_ONE])
    else $error("Clearing write lost a coincident event");
  chk_pin_priority: assert property (
    pend_a[0] |=> irq_source == SRC_PIN0 && irq_pending)
    else $error("Request pin 0 did not win priority");
  chk_fl_wide_off: assert property (
    tf_wide && !interrupt_flags_group_b[BIT_TIMER_FL]
    |=> !interrupt_flags_group_b[BIT_TIMER_FL])
    else $error("Timer FL set in 16-bit mode");

endmodule

// *** src/irf_flags_unused_guard.sv ***
// Holds no logic; every flag register lives in irf_flags

// *** verif/irf_periph_model.sv ***
// Behavioural model of the peripherals that raise internal requests
`timescale 1ns/1ps
module irf_periph_model
  import irf_pkg::*;
(
  input wire logic mclk,
  output irf_periph_t periph
);
  // Counters park at a mid value so no wrap happens unless a test asks for one
  initial begin
    periph = '0;
    periph.timer_a_count = 8'h10;
    periph.timer_b_count = 8'h10;
    periph.timer_c_count = 8'h10;
    periph.timer_f_low_count = 8'h01;
    periph.timer_f_high_count = 8'h01;
    periph.timer_f_low_compare = 8'h05;
    periph.timer_f_high_compare = 8'h06;
  end

  task automatic fire(input int code);
    @(posedge mclk);
    case (code)
      0: periph.timer_a_count <= 8'hff;
      2: periph.direct_transfer_on <= 1'b1;
      3: periph.converter_start_busy <= 1'b1;
      8: periph.timer_c_count <= 8'hff;
      9: periph.timer_c_count <= 8'h00;
      10: periph.timer_b_count <= 8'hff;
      default: ;
    endcase
    @(posedge mclk);
    case (code)
      0: periph.timer_a_count <= 8'h00;
      1: periph.serial_one_done <= 1'b1;
      2: periph.direct_transfer_after_sleep <= 1'b1;
      3: begin
        periph.converter_done <= 1'b1;
        periph.converter_start_busy <= 1'b0;
      end
      4: periph.serial_two_done <= 1'b1;
      5: periph.serial_two_abort <= 1'b1;
      6: periph.timer_f_high_count <= 8'h06;
      7: periph.timer_f_low_count <= 8'h05;
      8: periph.timer_c_count <= 8'h00;
      9: periph.timer_c_count <= 8'hff;
      10: periph.timer_b_count <= 8'h00;
      11: begin
        periph.timer_f_high_count <= 8'h06;
        periph.timer_f_low_count <= 8'h05;
      end
      default: ;
    endcase
    @(posedge mclk);
    periph.serial_one_done <= 1'b0;
    periph.direct_transfer_after_sleep <= 1'b0;
    periph.direct_transfer_on <= 1'b0;
    periph.converter_done <= 1'b0;
    periph.serial_two_done <= 1'b0;
    periph.serial_two_abort <= 1'b0;
    periph.timer_a_count <= 8'h10;
    periph.timer_b_count <= 8'h10;
    periph.timer_c_count <= 8'h10;
    periph.timer_f_low_count <= 8'h01;
    periph.timer_f_high_count <= 8'h01;
  endtask
endmodule

// *** verif/irf_flags_tb_top.sv ***
// Self-checking testbench of the interrupt request flags
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t ns: read %h, expected %h", $time, (got), (exp)); end end
module irf_flags_tb_top;
  import irf_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  irf_bus_t bus = '0;
  logic [IRF_DW-1:0] rdata;
  irf_periph_t periph;
  logic [IRF_NPIN-1:0] request_pin = 5'h1f;
  logic [IRF_NWAKE-1:0] wake_pin = 8'hff;
  logic timer_g_input_pin = 1'b1;
  logic irq_pending;
  irf_source_t irq_source;
  int miscompares = 0;
  int total_checks = 0;
  logic [IRF_AW-1:0] ofs;
  logic [IRF_DW-1:0] base;
  int bit_tab [12] = '{7, 6, 7, 6, 5, 5, 3, 2, 1, 1, 0, 3};
  irf_source_t src_tab [12] = '{SRC_TIMER_A, SRC_SERIAL_ONE, SRC_DIRECT, SRC_CONVERTER,
    SRC_SERIAL_TWO, SRC_SERIAL_TWO, SRC_TIMER_FH, SRC_TIMER_FL, SRC_TIMER_C, SRC_TIMER_C,
    SRC_TIMER_B, SRC_TIMER_FH};

  irf_flags i_irf_flags(.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .periph(periph),
    .request_pin(request_pin), .wake_pin(wake_pin), .timer_g_input_pin(timer_g_input_pin),
    .irq_pending(irq_pending), .irq_source(irq_source));
  irf_periph_model i_irf_periph_model(.mclk(mclk), .periph(periph));

  always #10 mclk = ~mclk;

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [IRF_AW-1:0] a, input logic [IRF_DW-1:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge, so sample just past it
  task automatic rchk(input logic [IRF_AW-1:0] a, input logic [IRF_DW-1:0] e);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rchk(OFS_FLAGS_A, 8'h20);
    rchk(OFS_FLAGS_B, 8'h00);
    rchk(OFS_WAKE_FLAGS, 8'h00);
    for (int a = 3; a < 9; a++) begin
      rchk(4'(a), 8'h00);
    end
    rchk(4'hf, 8'h00);
    wr(OFS_FLAGS_A, 8'hff);
    wr(OFS_FLAGS_B, 8'hff);
    wr(OFS_WAKE_FLAGS, 8'hff);
    wr(4'hf, 8'hff);
    rchk(OFS_FLAGS_A, 8'h20);
    rchk(OFS_FLAGS_B, 8'h00);
    rchk(OFS_WAKE_FLAGS, 8'h00);
    wr(OFS_FLAGS_A, 8'h00);
    rchk(OFS_FLAGS_A, 8'h20);
    wr(OFS_ENABLE_A, 8'hff);
    wr(OFS_ENABLE_B, 8'hff);
    wr(OFS_PIN_FUNC, 8'h1f);
    wr(OFS_WAKE_FUNC, 8'hff);
    wr(OFS_TIMER_CTRL, 8'h01);
    for (int c = 0; c < 12; c++) begin
      if (c == 11) begin
        wr(OFS_TIMER_CTRL, 8'h05);
      end
      ofs = (c < 2) ? OFS_FLAGS_A : OFS_FLAGS_B;
      base = (c < 2) ? 8'h20 : 8'h00;
      i_irf_periph_model.fire(c);
      idle(3);
      rchk(ofs, base | (8'h01 << bit_tab[c]));
      `CHK(irq_source, src_tab[c])
      `CHK(irq_pending, 1'b1)
      idle(20);
      rchk(ofs, base | (8'h01 << bit_tab[c]));
      wr(ofs, ~(8'h01 << bit_tab[c]));
      rchk(ofs, base);
    end
    i_irf_periph_model.fire(7);
    idle(3);
    rchk(OFS_FLAGS_B, 8'h00);
    wr(OFS_TIMER_CTRL, 8'h01);
    wr(OFS_ENABLE_B, 8'hfe);
    i_irf_periph_model.fire(10);
    idle(3);
    rchk(OFS_FLAGS_B, 8'h00);
    wr(OFS_ENABLE_B, 8'hff);
    // Clearing write lands on the very edge that samples the done pulse
    fork
      i_irf_periph_model.fire(1);
      begin
        @(posedge mclk);
        wr(OFS_FLAGS_A, 8'h00);
      end
    join
    idle(3);
    rchk(OFS_FLAGS_A, 8'h60);
    wr(OFS_FLAGS_A, 8'h00);
    for (int n = 0; n < 5; n++) begin
      wr(OFS_EDGE_SEL, 8'h00);
      @(posedge mclk) request_pin[n] <= 1'b0;
      idle(6);
      rchk(OFS_FLAGS_A, 8'h20 | (8'h01 << n));
      `CHK(irq_source, irf_source_t'(SRC_PIN0 + n))
      wr(OFS_FLAGS_A, ~(8'h01 << n));
      @(posedge mclk) request_pin[n] <= 1'b1;
      idle(6);
      rchk(OFS_FLAGS_A, 8'h20);
      wr(OFS_EDGE_SEL, 8'h01 << n);
      @(posedge mclk) request_pin[n] <= 1'b0;
      idle(6);
      rchk(OFS_FLAGS_A, 8'h20);
      @(posedge mclk) request_pin[n] <= 1'b1;
      idle(6);
      rchk(OFS_FLAGS_A, 8'h20 | (8'h01 << n));
      wr(OFS_FLAGS_A, ~(8'h01 << n));
    end
    wr(OFS_EDGE_SEL, 8'h00);
    @(posedge mclk) request_pin <= 5'h0e;
    idle(6);
    `CHK(irq_source, SRC_PIN0)
    wr(OFS_FLAGS_A, 8'hfe);
    idle(3);
    `CHK(irq_source, SRC_PIN4)
    @(posedge mclk) request_pin <= 5'h1f;
    wr(OFS_FLAGS_A, 8'h00);
    @(posedge mclk) timer_g_input_pin <= 1'b0;
    idle(6);
    rchk(OFS_FLAGS_B, 8'h10);
    `CHK(irq_source, SRC_TIMER_G)
    wr(OFS_FLAGS_B, 8'hef);
    @(posedge mclk) timer_g_input_pin <= 1'b1;
    idle(6);
    rchk(OFS_FLAGS_B, 8'h00);
    wr(OFS_TIMER_CTRL, 8'h03);
    @(posedge mclk) timer_g_input_pin <= 1'b0;
    idle(6);
    rchk(OFS_FLAGS_B, 8'h00);
    @(posedge mclk) timer_g_input_pin <= 1'b1;
    idle(6);
    rchk(OFS_FLAGS_B, 8'h10);
    wr(OFS_FLAGS_B, 8'hef);
    for (int n = 0; n < 8; n++) begin
      @(posedge mclk) wake_pin[n] <= 1'b0;
      idle(6);
      `CHK(irq_source, SRC_WAKE)
      @(posedge mclk) wake_pin[n] <= 1'b1;
      idle(6);
      rchk(OFS_WAKE_FLAGS, 8'h01 << n);
      wr(OFS_WAKE_FLAGS, 8'h00);
    end
    wr(OFS_ENABLE_A, 8'hdf);
    @(posedge mclk) wake_pin[0] <= 1'b0;
    idle(6);
    rchk(OFS_WAKE_FLAGS, 8'h00);
    `CHK(irq_pending, 1'b0)
    wr(OFS_PIN_FUNC, 8'h1e);
    @(posedge mclk) request_pin[0] <= 1'b0;
    idle(6);
    rchk(OFS_FLAGS_A, 8'h20);
    print_verdict();
  end
endmodule
